// ==== shared/module_mgmt_regs.vh ====
// constants for the module management controller: map, fields, reset values and timing
// Contract
// (RULE1) module is fully functional within 2000 ms of power-on, plug or reset release
// (RULE2) reset input low counts only when longer than 2 us; host holds it that long
// (RULE3) two-wire bus answers within 2000 ms of power-on
// (RULE4) data-not-ready bit 0 of status byte 2 clears and interrupt asserts within 2000 ms
// (RULE5) interrupt due to cleared data-not-ready marks full functionality
// (RULE6) low-power pin high enters lower power level within 100 us
// (RULE7) interrupt output goes low within 200 ms of a triggering condition
// (RULE8) interrupt releases within 500 us after the host reads and clears the flag
// (RULE9) entering receive loss-of-signal sets its flag and interrupt within 100 ms
// (RULE10) entering transmit fault sets its flag and interrupt within 200 ms
// (RULE11) any other condition sets its flag and interrupt within 200 ms
// (RULE12) setting a mask bit stops that flag driving the interrupt within 100 ms
// (RULE13) clearing a mask bit resumes that flag's interrupt within 100 ms
// (RULE14) select asserted: module answers bus transactions within 100 us
// (RULE15) select deasserted: module stops answering bus transactions within 100 us
// (RULE16) power-down or override bit set enters lower power level within 100 ms; code needs both bits set, override alone gives full power
// (RULE17) power-down bit cleared returns to full function within 300 ms
// (RULE18) mask and power delays count from the write's stop condition
// (RULE19) host reads the flag bytes after an interrupt to find its cause
// (RULE20) flags stay latched until read; interrupt holds while unmasked flag is set
// (RULE21) during reset and initialization report not ready and hold interrupt released
`ifndef MODULE_MGMT_REGS_VH
`define MODULE_MGMT_REGS_VH

// ****************************************
// clock and timing
// ****************************************
`define CLK_MHZ          200
`define T_INIT_MS        2000
`define INIT_CYC         (`T_INIT_MS * 1000 * `CLK_MHZ)
`define T_RESET_INIT_US  2
`define RESET_MIN_CYC    (`T_RESET_INIT_US * `CLK_MHZ)
`define T_LOW_POWER_PIN_US      100
`define T_IRQ_ON_MS      200
`define T_IRQ_OFF_US     500
`define T_SELECT_US      100

// ****************************************
// two-wire bus
// ****************************************
`define DEV_ADDR         7'h50

// ****************************************
// byte map
// ****************************************
`define ADR_STATUS       8'h02
`define ADR_FLAG_LOS     8'h03
`define ADR_FLAG_FAULT   8'h04
`define ADR_FLAG_OTHER   8'h05
`define ADR_POWER_CTRL   8'h5D
`define ADR_MASK_LOS     8'h64
`define ADR_MASK_FAULT   8'h65
`define ADR_MASK_OTHER   8'h66

// ****************************************
// fields and reset values
// ****************************************
`define BIT_NOT_READY    0
`define BIT_OVERRIDE     0
`define BIT_POWER_SET    1
`define MASK_RESET       4'h0
`define POWER_RESET      2'h0

`endif

// ==== rtl/pin_sync.v ====
// two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    // clock and control
    input  wire         ref_clk,
    input  wire         srst,
    input  wire         clk_en,
    // pins in, synchronised out
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);

    reg [W-1:0] stage1_q;
    reg [W-1:0] stage2_q;

    always @(posedge ref_clk) begin
        if (srst) begin
            stage1_q <= INIT;
            stage2_q <= INIT;
        end else if (clk_en) begin
            stage1_q <= d;
            stage2_q <= stage1_q;
        end
    end

    assign q = stage2_q;

endmodule // pin_sync

`default_nettype wire

// ==== rtl/module_mgmt_ctrl.v ====
// module management controller: init, reset qualification, flags, interrupt, power and bus slave
`timescale 1ns/1ps
`default_nettype none
`include "module_mgmt_regs.vh"

module module_mgmt_ctrl #(
    parameter [31:0] INIT_CYCLES = `INIT_CYC
) (
    // clock and control
    input  wire        ref_clk,
    input  wire        srst,
    input  wire        clk_en,
    // host control pins
    input  wire        module_reset_n,
    input  wire        bus_select_n,
    input  wire        low_power_pin,
    // two-wire management bus
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out,
    output reg         sda_oe,
    // monitored conditions, one bit per channel
    input  wire [3:0]  los_in,
    input  wire [3:0]  tx_fault_in,
    input  wire [3:0]  other_alarm_in,
    // status outputs
    output reg         interrupt_out_n,
    output reg         low_power_q,
    output reg         ready_q
);

    // ****************************************
    // input synchronisation
    // ****************************************
    wire [16:0] pins_s;
    pin_sync #(.W(17), .INIT(17'h1E000)) u_sync (
        .ref_clk (ref_clk),
        .srst    (srst),
        .clk_en  (clk_en),
        .d       ({scl_in, sda_in, module_reset_n, bus_select_n, low_power_pin,
                   other_alarm_in, tx_fault_in, los_in}),
        .q       (pins_s)
    );

    wire        scl_s   = pins_s[16];
    wire        sda_s   = pins_s[15];
    wire        rst_n_s = pins_s[14];
    wire        sel_n_s = pins_s[13];
    wire        lp_s    = pins_s[12];
    wire [11:0] cond_s  = pins_s[11:0];

    // ****************************************
    // reset qualification and initialization
    // ****************************************
    localparam [1:0] ST_INIT = 2'h0;
    localparam [1:0] ST_RUN  = 2'h1;
    localparam [1:0] ST_HELD = 2'h2;
    localparam [31:0] RST_MIN_W = `RESET_MIN_CYC;
    localparam [8:0]  RST_MIN   = RST_MIN_W[8:0];

    reg [1:0]  mode_q;
    reg [31:0] init_cnt_q;
    reg [8:0]  rst_cnt_q;
    reg        ready_evt_q;
    wire       run = (mode_q == ST_RUN);
    wire       rst_qual = !rst_n_s && (rst_cnt_q == RST_MIN);
    wire       clr_status;

    always @(posedge ref_clk) begin
        if (srst) begin
            rst_cnt_q <= 9'h000;
        end else if (clk_en) begin
            if (rst_n_s)
                rst_cnt_q <= 9'h000;
            else if (rst_cnt_q != RST_MIN)
                rst_cnt_q <= rst_cnt_q + 9'h001; // [RULE2]
        end
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            mode_q      <= ST_INIT;
            init_cnt_q  <= 32'h0000_0000;
            ready_evt_q <= 1'b0;
        end else if (clk_en) begin
            if (clr_status)
                ready_evt_q <= 1'b0;
            case (mode_q)
                ST_INIT: begin
                    if (rst_qual) begin
                        mode_q <= ST_HELD; // [RULE2]
                    end else if (init_cnt_q >= INIT_CYCLES - 32'h0000_0001) begin
                        mode_q      <= ST_RUN; // [RULE1] [RULE3]
                        ready_evt_q <= 1'b1;   // [RULE4] [RULE5]
                    end else begin
                        init_cnt_q <= init_cnt_q + 32'h0000_0001;
                    end
                end
                ST_RUN: begin
                    if (rst_qual) begin
                        mode_q      <= ST_HELD;
                        ready_evt_q <= 1'b0;
                    end
                end
                ST_HELD: begin
                    init_cnt_q  <= 32'h0000_0000;
                    ready_evt_q <= 1'b0; // [RULE21]
                    if (rst_n_s)
                        mode_q <= ST_INIT; // [RULE1]
                end
                default: begin
                    mode_q <= ST_INIT;
                end
            endcase
        end
    end

    // ****************************************
    // condition flags, clear on read
    // ****************************************
    reg  [11:0] cond_prev_q;
    reg  [11:0] flag_q;
    reg  [11:0] mask_q;
    wire [11:0] flag_clr;
    wire [11:0] rise = cond_s & ~cond_prev_q;

    always @(posedge ref_clk) begin
        if (srst)
            cond_prev_q <= 12'h000;
        else if (clk_en)
            cond_prev_q <= cond_s;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 12; gi = gi + 1) begin : g_flag
            always @(posedge ref_clk) begin
                if (srst)
                    flag_q[gi] <= 1'b0;
                else if (clk_en) begin
                    if (!run)
                        flag_q[gi] <= 1'b0; // [RULE21]
                    else
                        flag_q[gi] <= (flag_q[gi] & ~flag_clr[gi]) | rise[gi]; // [RULE9] [RULE10] [RULE11] [RULE20]
                end
            end
        end
    endgenerate

    // ****************************************
    // interrupt and power outputs
    // ****************************************
    reg [1:0] power_ctrl_q;
    wire      irq_any = (|(flag_q & ~mask_q)) | ready_evt_q; // [RULE12] [RULE13] [RULE20]

    always @(posedge ref_clk) begin
        if (srst) begin
            interrupt_out_n <= 1'b1;
            low_power_q     <= 1'b1;
            ready_q         <= 1'b0;
        end else if (clk_en) begin
            interrupt_out_n <= !(run && irq_any); // [RULE7] [RULE8] [RULE21]
            ready_q         <= run;
            if (power_ctrl_q[`BIT_OVERRIDE])
                low_power_q <= power_ctrl_q[`BIT_POWER_SET]; // [RULE16] [RULE17] [RULE18]
            else
                low_power_q <= lp_s; // [RULE6]
        end
    end

    // ****************************************
    // two-wire bus slave
    // ****************************************
    localparam [2:0] B_IDLE  = 3'h0;
    localparam [2:0] B_ADDR  = 3'h1;
    localparam [2:0] B_AACK  = 3'h2;
    localparam [2:0] B_WDATA = 3'h3;
    localparam [2:0] B_WACK  = 3'h4;
    localparam [2:0] B_RDATA = 3'h5;
    localparam [2:0] B_RACK  = 3'h6;

    reg  [2:0] bus_q;
    reg  [3:0] bit_cnt_q;
    reg  [7:0] shift_q;
    reg  [7:0] ptr_q;
    reg        rw_q;
    reg        first_q;
    reg        scl_prev_q;
    reg        sda_prev_q;
    reg  [7:0] rd_byte;
    reg  [2:0] rd_clr_q;
    reg        los_clr_q;

    wire scl_rise = scl_s & ~scl_prev_q;
    wire scl_fall = ~scl_s & scl_prev_q;
    wire start_c  = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    wire stop_c   = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    wire active   = run && !sel_n_s; // [RULE3] [RULE14] [RULE15]

    assign clr_status = rd_clr_q[0];
    assign flag_clr   = {{4{rd_clr_q[2]}}, {4{rd_clr_q[1]}}, {4{los_clr_q}}}; // [RULE8]

    always @* begin
        case (ptr_q)
            `ADR_STATUS:     rd_byte = {7'h00, !run};
            `ADR_FLAG_LOS:   rd_byte = {4'h0, flag_q[3:0]};
            `ADR_FLAG_FAULT: rd_byte = {4'h0, flag_q[7:4]};
            `ADR_FLAG_OTHER: rd_byte = {4'h0, flag_q[11:8]};
            `ADR_POWER_CTRL: rd_byte = {6'h00, power_ctrl_q};
            `ADR_MASK_LOS:   rd_byte = {4'h0, mask_q[3:0]};
            `ADR_MASK_FAULT: rd_byte = {4'h0, mask_q[7:4]};
            `ADR_MASK_OTHER: rd_byte = {4'h0, mask_q[11:8]};
            default:         rd_byte = 8'h00;
        endcase
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            bus_q        <= B_IDLE;
            bit_cnt_q    <= 4'h0;
            shift_q      <= 8'h00;
            ptr_q        <= 8'h00;
            rw_q         <= 1'b0;
            first_q      <= 1'b0;
            scl_prev_q   <= 1'b1;
            sda_prev_q   <= 1'b1;
            sda_out      <= 1'b0;
            sda_oe       <= 1'b0;
            mask_q       <= {3{`MASK_RESET}};
            power_ctrl_q <= `POWER_RESET;
            rd_clr_q     <= 3'h0;
            los_clr_q    <= 1'b0;
        end else if (clk_en) begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
            rd_clr_q   <= 3'h0;
            los_clr_q  <= 1'b0;
            if (!active) begin
                bus_q  <= B_IDLE; // [RULE15]
                sda_oe <= 1'b0;
                if (!run) begin
                    mask_q       <= {3{`MASK_RESET}};
                    power_ctrl_q <= `POWER_RESET;
                end
            end else if (start_c) begin
                bus_q     <= B_ADDR;
                bit_cnt_q <= 4'h0;
                sda_oe    <= 1'b0;
            end else if (stop_c) begin
                bus_q  <= B_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                case (bus_q)
                    B_ADDR, B_WDATA: begin
                        shift_q   <= {shift_q[6:0], sda_s};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    B_RACK: begin
                        if (sda_s)
                            bus_q <= B_IDLE;
                    end
                    default: begin
                        bit_cnt_q <= bit_cnt_q;
                    end
                endcase
            end else if (scl_fall) begin
                case (bus_q)
                    B_ADDR: begin
                        if (bit_cnt_q == 4'h8) begin
                            if (shift_q[7:1] == `DEV_ADDR) begin
                                bus_q  <= B_AACK;
                                rw_q   <= shift_q[0];
                                sda_oe <= 1'b1;
                            end else begin
                                bus_q <= B_IDLE;
                            end
                        end
                    end
                    B_WDATA: begin
                        if (bit_cnt_q == 4'h8) begin
                            bus_q  <= B_WACK;
                            sda_oe <= 1'b1;
                            if (first_q) begin
                                ptr_q   <= shift_q;
                                first_q <= 1'b0;
                            end else begin
                                ptr_q <= ptr_q + 8'h01;
                                case (ptr_q)
                                    `ADR_POWER_CTRL: power_ctrl_q   <= shift_q[1:0]; // [RULE16] [RULE17]
                                    `ADR_MASK_LOS:   mask_q[3:0]    <= shift_q[3:0]; // [RULE12] [RULE13]
                                    `ADR_MASK_FAULT: mask_q[7:4]    <= shift_q[3:0];
                                    `ADR_MASK_OTHER: mask_q[11:8]   <= shift_q[3:0];
                                    default:         power_ctrl_q   <= power_ctrl_q;
                                endcase
                            end
                        end
                    end
                    B_AACK, B_RACK: begin
                        if (bus_q == B_AACK && !rw_q) begin
                            bus_q     <= B_WDATA;
                            bit_cnt_q <= 4'h0;
                            first_q   <= 1'b1;
                            sda_oe    <= 1'b0;
                        end else begin
                            bus_q     <= B_RDATA;
                            shift_q   <= {rd_byte[6:0], 1'b0};
                            sda_oe    <= !rd_byte[7];
                            bit_cnt_q <= 4'h1;
                            ptr_q     <= ptr_q + 8'h01;
                            rd_clr_q  <= {ptr_q == `ADR_FLAG_OTHER, ptr_q == `ADR_FLAG_FAULT,
                                          ptr_q == `ADR_STATUS}; // [RULE4] [RULE8] [RULE19]
                            los_clr_q <= (ptr_q == `ADR_FLAG_LOS); // [RULE8]
                        end
                    end
                    B_WACK: begin
                        bus_q     <= B_WDATA;
                        bit_cnt_q <= 4'h0;
                        sda_oe    <= 1'b0;
                    end
                    B_RDATA: begin
                        if (bit_cnt_q == 4'h8) begin
                            bus_q  <= B_RACK;
                            sda_oe <= 1'b0;
                        end else begin
                            sda_oe    <= !shift_q[7];
                            shift_q   <= {shift_q[6:0], 1'b0};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule // module_mgmt_ctrl

`default_nettype wire

// ==== test/mgmt_ctrl_assertions.sv ====
// checker bound to the module management controller ports
`timescale 1ns/1ps
`default_nettype none
module mgmt_ctrl_checker #(
    parameter [31:0] INIT_CYCLES = 100
) (
    // clock and control
    input wire logic       ref_clk,
    input wire logic       srst,
    input wire logic       clk_en,
    // host pins and bus
    input wire logic       module_reset_n,
    input wire logic       bus_select_n,
    input wire logic       low_power_pin,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    // conditions
    input wire logic [3:0] los_in,
    input wire logic [3:0] tx_fault_in,
    input wire logic [3:0] other_alarm_in,
    // status
    input wire logic       interrupt_out_n,
    input wire logic       low_power_q,
    input wire logic       ready_q
);
    logic [31:0] wait_q;
    logic [15:0] low_q;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    // cycles spent not ready since the last reset, and cycles the reset pin has been low
    always_ff @(posedge ref_clk) begin
        if (srst || !module_reset_n || ready_q) begin
            wait_q <= 32'h0;
        end else begin
            wait_q <= wait_q + 32'h1;
        end
        if (srst || module_reset_n) begin
            low_q <= 16'h0;
        end else if (low_q != 16'hFFFF) begin
            low_q <= low_q + 16'h1;
        end
    end

    property p_reset_out;
        $fell(srst) |-> interrupt_out_n && low_power_q && !ready_q && !sda_oe;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs wrong after reset");
    property p_init_bound;
        !ready_q |-> wait_q <= INIT_CYCLES + 10;
    endproperty
    a_init_bound: assert property (p_init_bound) else $error("init too long");
    property p_init_early;
        $rose(ready_q) |-> wait_q >= INIT_CYCLES - 1;
    endproperty
    a_init_early: assert property (p_init_early) else $error("ready too early");
    property p_ready_irq;
        $rose(ready_q) |-> ##[0:4] !interrupt_out_n;
    endproperty
    a_ready_irq: assert property (p_ready_irq) else $error("no ready interrupt");
    property p_idle_irq;
        !ready_q [*2] |-> interrupt_out_n;
    endproperty
    a_idle_irq: assert property (p_idle_irq) else $error("interrupt while not ready");
    property p_idle_bus;
        !ready_q [*3] |-> !sda_oe;
    endproperty
    a_idle_bus: assert property (p_idle_bus) else $error("bus driven while not ready");
    property p_deselect;
        bus_select_n [*6] |-> !sda_oe;
    endproperty
    a_deselect: assert property (p_deselect) else $error("bus driven while deselected");
    property p_short_reset;
        low_q inside {[1:395]} && $past(ready_q) |-> ready_q;
    endproperty
    a_short_reset: assert property (p_short_reset) else $error("short reset pulse taken");
    property p_long_reset;
        low_q == 16'h019A |-> !ready_q && interrupt_out_n;
    endproperty
    a_long_reset: assert property (p_long_reset) else $error("long reset pulse missed");
endmodule // mgmt_ctrl_checker

bind module_mgmt_ctrl mgmt_ctrl_checker #(.INIT_CYCLES(INIT_CYCLES)) u_mgmt_ctrl_checker (
    .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .module_reset_n(module_reset_n),
    .bus_select_n(bus_select_n), .low_power_pin(low_power_pin), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .los_in(los_in), .tx_fault_in(tx_fault_in),
    .other_alarm_in(other_alarm_in), .interrupt_out_n(interrupt_out_n), .low_power_q(low_power_q),
    .ready_q(ready_q)
);
`default_nettype wire

// ==== test/host_model.sv ====
// host board two-wire bus master with a pull-up on the data line
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // device side of the data line
    input  wire logic dev_sda_out,
    input  wire logic dev_sda_oe,
    // resolved lines
    output var  logic scl_line,
    output wire logic sda_line
);
    logic host_low_q;

    initial begin
        scl_line = 1'b1;
        host_low_q = 1'b0;
    end

    // open drain: high unless a side pulls low
    assign sda_line = (dev_sda_oe ? dev_sda_out : 1'b1) & ~host_low_q;

    task automatic start_cond;
        host_low_q = 1'b0;
        #40 scl_line = 1'b1;
        #40 host_low_q = 1'b1;
        #40 scl_line = 1'b0;
        #40;
    endtask

    task automatic stop_cond;
        host_low_q = 1'b1;
        #40 scl_line = 1'b1;
        #40 host_low_q = 1'b0;
        #80;
    endtask

    task automatic bit_io(input logic b, output logic r);
        host_low_q = !b;
        #40 scl_line = 1'b1;
        #40 r = sda_line;
        #40 scl_line = 1'b0;
        #40;
    endtask

    // eight bits msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic nak);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        bit_io(last, nak);
    endtask
endmodule // host_model
`default_nettype wire

// ==== test/tb.sv ====
// testbench for the module management controller
`timescale 1ns/1ps
`default_nettype none
`include "module_mgmt_regs.vh"
module tb;
    localparam int         INIT_N = 100;
    localparam logic [7:0] P_OVR  = 8'(1 << `BIT_OVERRIDE);
    localparam logic [7:0] P_SET  = 8'(1 << `BIT_POWER_SET);
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic        module_reset_n = 1'b1;
    logic        bus_select_n = 1'b0;
    logic        low_power_pin = 1'b0;
    logic        clk_en = 1'b1;
    logic [11:0] cond = 12'h000;
    wire         scl_in;
    wire         sda_in;
    wire         sda_out;
    wire         sda_oe;
    wire         interrupt_out_n;
    wire         low_power_q;
    wire         ready_q;
    int          fails = 0;
    int          n_compared = 0;

    module_mgmt_ctrl #(.INIT_CYCLES(INIT_N)) u_module_mgmt_ctrl (
        .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .module_reset_n(module_reset_n),
        .bus_select_n(bus_select_n), .low_power_pin(low_power_pin), .scl_in(scl_in), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .los_in(cond[3:0]), .tx_fault_in(cond[7:4]),
        .other_alarm_in(cond[11:8]), .interrupt_out_n(interrupt_out_n), .low_power_q(low_power_q),
        .ready_q(ready_q)
    );
    host_model u_host_model (
        .dev_sda_out(sda_out), .dev_sda_oe(sda_oe), .scl_line(scl_in), .sda_line(sda_in)
    );

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus_write(input logic [7:0] adr, input logic [7:0] d, input logic exp_ack);
        logic [7:0] rx;
        logic n0, n1, n2;
        u_host_model.start_cond();
        u_host_model.xfer({`DEV_ADDR, 1'b0}, 1'b1, rx, n0);
        u_host_model.xfer(adr, 1'b1, rx, n1);
        u_host_model.xfer(d, 1'b1, rx, n2);
        u_host_model.stop_cond();
        cyc(1);
        check("write ack", {7'h00, exp_ack}, {7'h00, !(n0 | n1 | n2)});
    endtask

    task automatic bus_read(input logic [7:0] adr, input logic [7:0] exp);
        logic [7:0] rx, d;
        logic n0, n1, n2, n3;
        u_host_model.start_cond();
        u_host_model.xfer({`DEV_ADDR, 1'b0}, 1'b1, rx, n0);
        u_host_model.xfer(adr, 1'b1, rx, n1);
        u_host_model.start_cond();
        u_host_model.xfer({`DEV_ADDR, 1'b1}, 1'b1, rx, n2);
        u_host_model.xfer(8'hFF, 1'b1, d, n3);
        u_host_model.stop_cond();
        cyc(1);
        check("read ack", 8'h01, {7'h00, !(n0 | n1 | n2)});
        check("read data", exp, d);
    endtask

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #400000;
        fails++;
        complete_run();
    end

    initial begin
        cyc(3);
        check("ready in reset", 8'h00, ready_q);
        srst = 1'b0;
        cyc(INIT_N - 10);
        check("irq in init", 8'h01, interrupt_out_n);
        cyc(20);
        check("ready", 8'h01, ready_q);
        check("ready irq", 8'h00, interrupt_out_n);
        bus_read(`ADR_STATUS, 8'h00);
        check("irq after status", 8'h01, interrupt_out_n);
        $display("init test done");
        bus_select_n = 1'b1;
        cyc(4);
        bus_write(`ADR_MASK_LOS, 8'h0F, 1'b0);
        bus_select_n = 1'b0;
        cyc(4);
        bus_read(`ADR_MASK_LOS, 8'h00);
        bus_read(8'h7F, 8'h00);
        $display("select test done");
        for (int k = 0; k < 3; k++) begin
            cond[5 * k + 1] = 1'b1;
            cyc(10);
            check("flag irq", 8'h00, interrupt_out_n);
            cond[5 * k + 1] = 1'b0;
            cyc(10);
            check("latched irq", 8'h00, interrupt_out_n);
            bus_read(8'(`ADR_FLAG_LOS + k), 8'(1 << (k + 1)));
            check("irq after flag read", 8'h01, interrupt_out_n);
            bus_read(8'(`ADR_FLAG_LOS + k), 8'h00);
            bus_write(8'(`ADR_MASK_LOS + k), 8'h01, 1'b1);
            bus_read(8'(`ADR_MASK_LOS + k), 8'h01);
            cond[4 * k] = 1'b1;
            cyc(10);
            check("masked irq", 8'h01, interrupt_out_n);
            cond[4 * k] = 1'b0;
            bus_write(8'(`ADR_MASK_LOS + k), 8'h00, 1'b1);
            cyc(4);
            check("unmasked irq", 8'h00, interrupt_out_n);
            bus_read(8'(`ADR_FLAG_LOS + k), 8'h01);
        end
        $display("flag test done");
        low_power_pin = 1'b1;
        cyc(5);
        check("pin low power", 8'h01, low_power_q);
        bus_write(`ADR_POWER_CTRL, P_OVR, 1'b1);
        check("override full power", 8'h00, low_power_q);
        check("ready in full power", 8'h01, ready_q);
        bus_write(`ADR_POWER_CTRL, P_OVR | P_SET, 1'b1);
        check("set low power", 8'h01, low_power_q);
        bus_write(`ADR_POWER_CTRL, 8'h00, 1'b1);
        low_power_pin = 1'b0;
        cyc(5);
        check("pin full power", 8'h00, low_power_q);
        clk_en = 1'b0;
        cond[2] = 1'b1;
        cyc(10);
        check("frozen irq", 8'h01, interrupt_out_n);
        clk_en = 1'b1;
        cyc(10);
        check("thawed irq", 8'h00, interrupt_out_n);
        cond[2] = 1'b0;
        bus_read(`ADR_FLAG_LOS, 8'h04);
        $display("power test done");
        module_reset_n = 1'b0;
        cyc(300);
        module_reset_n = 1'b1;
        cyc(5);
        check("short reset", 8'h01, ready_q);
        module_reset_n = 1'b0;
        cyc(450);
        check("held ready", 8'h00, ready_q);
        check("held irq", 8'h01, interrupt_out_n);
        module_reset_n = 1'b1;
        cyc(INIT_N + 20);
        check("ready after reset", 8'h01, ready_q);
        check("irq after reset", 8'h00, interrupt_out_n);
        bus_read(`ADR_STATUS, 8'h00);
        $display("reset test done");
        complete_run();
    end
endmodule // tb
`default_nettype wire
